// [four_bit_universal_shift_register_tb.sv]
// Self-checking bench for the universal shift register and its trail.
// Assumes the package, the design files, the checker and the reader.
`timescale 1ns/100ps
`default_nettype none
module four_bit_universal_shift_register_tb;
  import shift_reg_pkg::*;
  logic        clk, resetn, op_valid, op_ready, op_dropped;
  logic        snap_valid, snap_ready, stall, lsi, rsi;
  logic [1:0]  sel;
  logic [3:0]  pin, word, model;
  logic [15:0] cnt, ecnt;
  mode_t       amode;
  snapshot_t   sdata;
  snapshot_t   q[$];
  int          err_count, check_count, cycles;
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  universal_shift_register uut (.clk(clk), .resetn(resetn),
    .mode_select_first(sel[1]), .mode_select_second(sel[0]),
    .left_serial_in(lsi), .right_serial_in(rsi), .parallel_in_bit_zero(pin[0]),
    .parallel_in_bit_one(pin[1]), .parallel_in_bit_two(pin[2]),
    .parallel_in_bit_three(pin[3]), .op_valid(op_valid), .op_ready(op_ready),
    .stage_out_zero(word[0]), .stage_out_one(word[1]), .stage_out_two(word[2]),
    .stage_out_three(word[3]), .applied_mode(amode), .op_count(cnt),
    .op_dropped(op_dropped), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(sdata));
  snap_reader rdr (.clk(clk), .stall(stall), .snap_ready(snap_ready));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Offer one operation, hold it until taken, then note what must follow
  task automatic op(input logic [1:0] s, input logic [3:0] d, input logic l, input logic r);
    sel = s;
    pin = d;
    lsi = l;
    rsi = r;
    op_valid = 1'b1;
    // Ready only moves on an edge, so read it between edges, never at one
    while (op_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    case (s)
      SEL_LOAD:  model = d;
      SEL_RIGHT: model = {r, model[3:1]};
      SEL_LEFT:  model = {model[2:0], l};
      default:   model = model;
    endcase
    ecnt = ecnt + 16'h0001;
    q.push_back(snapshot_t'({s, model}));
    #1;
    check({12'h000, word}, {12'h000, model});
    check({14'h0, amode}, {14'h0, s});
    check(cnt, ecnt);
  endtask
  // Each trail entry about to be popped is matched against the oldest note;
  // looked at mid-cycle, where the head and its handshake have settled
  always @(negedge clk) begin
    if (resetn && snap_valid === 1'b1 && snap_ready === 1'b1) begin
      check({10'h000, sdata}, {10'h000, q.pop_front()});
    end
  end
  // Hang guard: far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0000_b6d7));
    {resetn, op_valid, lsi, rsi, stall} = 5'b00001;
    {sel, pin, model, ecnt} = {2'h3, 4'h0, 4'h0, 16'h0000};
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    check({12'h000, word}, 16'h0000);
    @(posedge clk);
    #1;
    // Reader stalled: sixteen operations fill the trail
    repeat (16) op(2'($urandom), 4'($urandom), 1'($urandom), 1'($urandom));
    op_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1 check({15'h0, op_ready}, 16'h0000);
    check({15'h0, op_dropped}, 16'h0000);
    {op_valid, sel, pin} = {1'b1, 2'h0, ~model};
    repeat (2) @(posedge clk);
    #1 check({12'h000, word}, {12'h000, model});
    check({15'h0, op_dropped}, 16'h0001);
    stall = 1'b0;
    // Random back-to-back traffic with the reader stalling at will
    repeat (200) op(2'($urandom), 4'($urandom), 1'($urandom), 1'($urandom));
    op_valid = 1'b0;
    for (int i = 0; i < 200 && q.size() > 0; i++) @(posedge clk);
    #1 check({15'h0, snap_valid}, 16'h0000);
    give_verdict();
  end
endmodule
bind universal_shift_register usr_checker chk (.clk(clk), .resetn(resetn),
  .mode_select_first(mode_select_first), .mode_select_second(mode_select_second),
  .left_serial_in(left_serial_in), .right_serial_in(right_serial_in),
  .parallel_in_bit_zero(parallel_in_bit_zero), .parallel_in_bit_one(parallel_in_bit_one),
  .parallel_in_bit_two(parallel_in_bit_two), .parallel_in_bit_three(parallel_in_bit_three),
  .op_valid(op_valid), .op_ready(op_ready), .stage_out_zero(stage_out_zero),
  .stage_out_one(stage_out_one), .stage_out_two(stage_out_two),
  .stage_out_three(stage_out_three), .applied_mode(applied_mode), .op_count(op_count));
`default_nettype wire

// [shift_reg_pkg.sv]
// Shared constants and types for the four-stage universal shift register.
// Assumes a single 20 MHz clock domain and synchronous, active-low reset.

package shift_reg_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int STAGES     = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int OP_COUNT_W = 16;

  // ------------------------------------------------------------------
  // Select encodings as seen on the two select pins {first, second}
  // ------------------------------------------------------------------
  localparam logic [1:0] SEL_LOAD  = 2'h0;
  localparam logic [1:0] SEL_RIGHT = 2'h1;
  localparam logic [1:0] SEL_LEFT  = 2'h2;
  localparam logic [1:0] SEL_HOLD  = 2'h3;

  // ------------------------------------------------------------------
  // Values after reset, and the count step
  // ------------------------------------------------------------------
  localparam logic [STAGES-1:0]     STAGE_RESET    = 4'h0;
  localparam logic [OP_COUNT_W-1:0] OP_COUNT_RESET = 16'h0000;
  localparam logic [OP_COUNT_W-1:0] OP_COUNT_STEP  = 16'h0001;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LOAD,
    MODE_RIGHT,
    MODE_LEFT,
    MODE_HOLD
  } mode_t;

  typedef struct packed {
    logic first;
    logic second;
  } select_t;

  // One operation request as presented on the input pins
  typedef struct packed {
    select_t           sel;
    logic              left_serial_in;
    logic              right_serial_in;
    logic [STAGES-1:0] parallel_in;
  } op_req_t;

  // Record of one applied operation and the word it produced
  typedef struct packed {
    mode_t             mode;
    logic [STAGES-1:0] word;
  } snapshot_t;

  localparam int SNAP_W = $bits(snapshot_t);

  // Map the select pins onto an operating mode
  function automatic mode_t decode_mode(input select_t s);
    mode_t m;
    m = MODE_HOLD;
    if ({s.first, s.second} == SEL_LOAD) begin
      m = MODE_LOAD;
    end else if ({s.first, s.second} == SEL_RIGHT) begin
      m = MODE_RIGHT;
    end else if ({s.first, s.second} == SEL_LEFT) begin
      m = MODE_LEFT;
    end
    return m;
  endfunction

endpackage

// [snap_reader.sv]
// Far-side reader of the snapshot trail with random stalls.
// Assumes the bench seeds the random generator before reset is released.
`timescale 1ns/100ps
`default_nettype none
module snap_reader (
  input  wire logic clk,
  input  wire logic stall,
  output var logic  snap_ready
);
  initial snap_ready = 1'b0;
  // Ready moves just after the edge; a forced stall lets the trail fill
  always @(posedge clk) begin
    snap_ready <= #1 !stall && ($urandom_range(3) != 0);
  end
endmodule
`default_nettype wire

// [snapshot_fifo.sv]
// Synchronous first-in first-out buffer with valid/ready on both sides.
// Assumes one clock; status flags are registered so in_ready and out_valid come from flops.

`timescale 1ns/100ps
`default_nettype none

module snapshot_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Occupancy after this edge
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CNT_W'(1);
    end else if (pop && !push) begin
      next_count = count - CNT_W'(1);
    end
  end

  // Storage; no reset needed, guarded by the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and registered flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PTR_W'(1);
      end
      count     <= next_count;
      in_ready  <= (next_count != FULL_COUNT);
      out_valid <= (next_count != '0);
    end
  end

endmodule

`default_nettype wire

// [stage_next_mux.sv]
// Next-value steering for the four storage stages.
// Purely combinational; the caller registers the result only on edges where a request is accepted.

`timescale 1ns/100ps
`default_nettype none

module stage_next_mux (
  input  wire shift_reg_pkg::mode_t              mode,
  input  wire logic [shift_reg_pkg::STAGES-1:0] cur_word,
  input  wire shift_reg_pkg::op_req_t            req,
  output logic [shift_reg_pkg::STAGES-1:0]      next_word
);
  import shift_reg_pkg::*;

  // Mode picks the data path into each stage; the clock is never touched
  always_comb begin
    next_word = cur_word;
    case (mode)
      MODE_LOAD: begin
        next_word = req.parallel_in;
      end
      MODE_RIGHT: begin
        next_word = {req.right_serial_in, cur_word[3:1]};
      end
      MODE_LEFT: begin
        next_word = {cur_word[2:0], req.left_serial_in};
      end
      default: begin
        next_word = cur_word;
      end
    endcase
  end

endmodule

`default_nettype wire

// [universal_shift_register.sv]
// Four-stage universal shift register with a snapshot trail buffer.
// Assumes surrounding synchronous logic drives selects and data on clk.

`timescale 1ns/100ps
`default_nettype none

module universal_shift_register (
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic                                mode_select_first,
  input  wire logic                                mode_select_second,
  input  wire logic                                left_serial_in,
  input  wire logic                                right_serial_in,
  input  wire logic                                parallel_in_bit_zero,
  input  wire logic                                parallel_in_bit_one,
  input  wire logic                                parallel_in_bit_two,
  input  wire logic                                parallel_in_bit_three,
  input  wire logic                                op_valid,
  output logic                                     op_ready,
  output logic                                     stage_out_zero,
  output logic                                     stage_out_one,
  output logic                                     stage_out_two,
  output logic                                     stage_out_three,
  output shift_reg_pkg::mode_t                     applied_mode,
  output logic [shift_reg_pkg::OP_COUNT_W-1:0]     op_count,
  output logic                                     op_dropped,
  output logic                                     snap_valid,
  input  wire logic                                snap_ready,
  output shift_reg_pkg::snapshot_t                 snap_data
);
  import shift_reg_pkg::*;

  // ------------------------------------------------------------------
  // Internal signals
  // ------------------------------------------------------------------
  op_req_t           req;
  mode_t             req_mode;
  logic [STAGES-1:0] word;
  logic [STAGES-1:0] next_word;
  logic              accept;
  snapshot_t         push_snap;
  logic [SNAP_W-1:0] fifo_out;

  // ------------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------------

  // Gather the pins into one request so the steering sees a single word
  // One driver for the whole struct keeps the multi-driver checks quiet
  assign req = '{
    sel:             '{first: mode_select_first, second: mode_select_second},
    left_serial_in:  left_serial_in,
    right_serial_in: right_serial_in,
    parallel_in:     {parallel_in_bit_three, parallel_in_bit_two,
                      parallel_in_bit_one, parallel_in_bit_zero}
  };

  assign req_mode = decode_mode(req.sel);

  // An operation only takes effect while the trail buffer has room,
  // so no applied operation is ever missing from the snapshot trail
  assign accept = op_valid && op_ready;

  // ------------------------------------------------------------------
  // Stage steering
  // ------------------------------------------------------------------

  stage_next_mux u_next (
    .mode      (req_mode),
    .cur_word  (word),
    .req       (req),
    .next_word (next_word)
  );

  // ------------------------------------------------------------------
  // Storage stages
  // ------------------------------------------------------------------

  // update on rising edge only
  // Every stage sees every edge but loads only on accept; a refused request keeps
  // the old word through the enable, not through the mux path the hold mode uses.
  // cleared only as a defined start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word <= STAGE_RESET;
    end else if (accept) begin
      word <= next_word;
    end
  end

  assign stage_out_zero  = word[0];
  assign stage_out_one   = word[1];
  assign stage_out_two   = word[2];
  assign stage_out_three = word[3];

  // ------------------------------------------------------------------
  // Status
  // ------------------------------------------------------------------

  // Mode of the last operation that took effect
  always_ff @(posedge clk) begin
    if (!resetn) begin
      applied_mode <= MODE_HOLD;
    end else if (accept) begin
      applied_mode <= req_mode;
    end
  end

  // Wrapping count of applied operations, hold included
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_count <= OP_COUNT_RESET;
    end else if (accept) begin
      op_count <= op_count + OP_COUNT_STEP;
    end
  end

  // Sticky: a request was offered while op_ready was low (buffer full, or the first cycle after reset).
  // Only reset clears it, so no set/clear race exists.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_dropped <= 1'b0;
    end else if (op_valid && !op_ready) begin
      op_dropped <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Snapshot trail
  // ------------------------------------------------------------------

  // Each applied operation logs its mode and the word it produced
  assign push_snap      = '{mode: req_mode, word: next_word};
  assign snap_data      = snapshot_t'(fifo_out);

  // A stalled reader fills the buffer, which then drops op_ready
  snapshot_fifo #(
    .WIDTH (SNAP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_trail (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (op_valid),
    .in_ready  (op_ready),
    .in_data   (push_snap),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (fifo_out)
  );

endmodule

`default_nettype wire

// [usr_monitor.sv]
// Port checker for the four-stage universal shift register.
// Assumes it is bound to the top module; one clock, sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module usr_checker (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 mode_select_first,
  input wire logic                 mode_select_second,
  input wire logic                 left_serial_in,
  input wire logic                 right_serial_in,
  input wire logic                 parallel_in_bit_zero,
  input wire logic                 parallel_in_bit_one,
  input wire logic                 parallel_in_bit_two,
  input wire logic                 parallel_in_bit_three,
  input wire logic                 op_valid,
  input wire logic                 op_ready,
  input wire logic                 stage_out_zero,
  input wire logic                 stage_out_one,
  input wire logic                 stage_out_two,
  input wire logic                 stage_out_three,
  input wire shift_reg_pkg::mode_t applied_mode,
  input wire logic [15:0]          op_count
);
  import shift_reg_pkg::*;
  // ----------------------------------------------------------------
  // Helper views
  // ----------------------------------------------------------------
  logic [3:0] w;
  logic [1:0] sel;
  logic       acc;
  // Word and selects gathered once so each property stays short
  assign w   = {stage_out_three, stage_out_two, stage_out_one, stage_out_zero};
  assign sel = {mode_select_first, mode_select_second};
  assign acc = op_valid && op_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_load_takes_data: assert property (acc && sel == 2'h0 |=> w == $past(
    {parallel_in_bit_three, parallel_in_bit_two, parallel_in_bit_one, parallel_in_bit_zero}))
    else $error("load word wrong");
  a_right_shift_word: assert property (acc && sel == 2'h1 |=>
    w == {$past(right_serial_in), $past(w[3:1])}) else $error("right shift wrong");
  a_left_shift_word: assert property (acc && sel == 2'h2 |=>
    w == {$past(w[2:0]), $past(left_serial_in)}) else $error("left shift wrong");
  a_hold_keeps_word: assert property (acc && sel == 2'h3 |=> $stable(w))
    else $error("hold changed word");
  a_refused_keeps_word: assert property (!op_ready |=> $stable(w))
    else $error("word changed while refusing");
  a_change_has_cause: assert property ($past(resetn) && w != $past(w) |-> $past(acc))
    else $error("word changed without an operation");
  a_mode_follows_sel: assert property (acc |=> applied_mode == mode_t'($past(sel)))
    else $error("reported mode wrong");
  a_count_one_step: assert property (acc |=> op_count == $past(op_count) + 16'h0001)
    else $error("operation count wrong");
  // Main scenarios reached
  c_right: cover property (acc && sel == 2'h1);
  c_left: cover property (acc && sel == 2'h2);
  c_refused: cover property (op_valid && !op_ready);
endmodule
`default_nettype wire
